// ---- asr_pkg.sv ----
// Package for the host-side controller of an asynchronous 32K x 16 static memory.
// Assumes a 100 MHz system clock; all pin timing is counted in whole cycles of it.
package asr_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int CLK_PERIOD_NS = 10;
    // Fastest grade figures in ns.
    localparam int T_RC_NS = 10;
    localparam int T_AA_NS = 10;
    localparam int T_DOE_NS = 5;
    localparam int T_HZOE_NS = 5;
    localparam int T_WC_NS = 10;
    localparam int T_PWE_NS = 7;
    localparam int T_AW_NS = 7;
    localparam int T_SD_NS = 5;
    // Least times round up, never below one cycle.
    // The read wait also covers the two synchroniser stages on the data pins.
    localparam int SYNC_STG = 2;
    localparam int RD_CYC = ((T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) + SYNC_STG;
    localparam int WR_RAW = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC = (WR_RAW < 1) ? 1 : WR_RAW;
    localparam int TURN_CYC = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RSET = 5'h02,
        ST_READ = 5'h04,
        ST_WRIT = 5'h08,
        ST_TURN = 5'h10
    } asr_state_e;

    // Memory pins as driven by the host.
    typedef struct packed {
        logic [ADDR_W-1:0] word_addr;
        logic chip_sel_n;
        logic write_n;
        logic out_en_n;
        logic upper_byte_sel_n;
        logic lower_byte_sel_n;
        logic [DATA_W-1:0] data_out;
        logic [DATA_W-1:0] data_oe;
    } asr_pins_s;

    typedef struct packed {
        asr_state_e state;
        logic [CNT_W-1:0] cnt;
        asr_pins_s pins;
        logic ready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic wr_pending;
        logic [DATA_W-1:0] din_meta;
        logic [DATA_W-1:0] din_sync;
    } asr_state_s;
endpackage : asr_pkg

// ---- asr_ctrl.sv ----
// Host controller that runs single read and write cycles on an async 32K x 16 memory.
// Assumes a user on sys_clk_in and an external tristate merge of the data lines.
// Operation
// - Write spans overlap of select, strobe, byte.
// - Host times data to terminating edge.
// - Address set-up 7 ns, hold 0 ns.
// - Address valid before write strobe falls.
// - Byte select 7 ns, chip select 8 ns.
// - Address valid before chip select falls.
`timescale 1ns/1ps
module asr_ctrl #(
    parameter int ADDR_W = asr_pkg::ADDR_W,
    parameter int DATA_W = asr_pkg::DATA_W
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // User request
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    input wire logic [1:0] req_byte_en_in,
    output logic req_ready_out,
    // User read answer
    output logic rd_valid_out,
    output logic [DATA_W-1:0] rd_data_out,
    // Memory pins
    output logic [ADDR_W-1:0] word_addr_out,
    output logic chip_sel_n_out,
    output logic write_n_out,
    output logic out_en_n_out,
    output logic upper_byte_sel_n_out,
    output logic lower_byte_sel_n_out,
    input wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0] data_lines_out,
    output logic [DATA_W-1:0] data_lines_oe_out
);
    // The pins fix both widths; the counter must hold every wait.
    if (ADDR_W != asr_pkg::ADDR_W) begin : g_bad_addr_w
        $error("asr_ctrl: address width must match the memory pins");
    end
    if (DATA_W != asr_pkg::DATA_W) begin : g_bad_data_w
        $error("asr_ctrl: data width must match the memory pins");
    end
    if (DATA_W != 2 * asr_pkg::BYTE_W) begin : g_bad_lanes
        $error("asr_ctrl: the data lines must split into two byte lanes");
    end
    if (asr_pkg::RD_CYC < 1 || asr_pkg::RD_CYC >= (1 << asr_pkg::CNT_W)) begin : g_bad_rd
        $error("asr_ctrl: read wait does not fit the counter");
    end
    if (asr_pkg::WR_CYC < 1 || asr_pkg::WR_CYC >= (1 << asr_pkg::CNT_W)) begin : g_bad_wr
        $error("asr_ctrl: write pulse does not fit the counter");
    end
    if (asr_pkg::TURN_CYC < 1 || asr_pkg::TURN_CYC >= (1 << asr_pkg::CNT_W)) begin : g_bad_turn
        $error("asr_ctrl: turnaround does not fit the counter");
    end

    // Waits count down to one; the state moves on in the cycle that sees one.
    localparam logic [asr_pkg::CNT_W-1:0] RD_N = asr_pkg::CNT_W'(asr_pkg::RD_CYC);
    localparam logic [asr_pkg::CNT_W-1:0] WR_N = asr_pkg::CNT_W'(asr_pkg::WR_CYC);
    localparam logic [asr_pkg::CNT_W-1:0] TURN_N = asr_pkg::CNT_W'(asr_pkg::TURN_CYC);
    localparam logic [asr_pkg::CNT_W-1:0] CNT_ONE = 4'h1;

    asr_pkg::asr_state_s st_q;
    asr_pkg::asr_state_s st_d;

    // Defaults hold every pin; only the state that owns a pin moves it.
    always_comb begin
        st_d = st_q;
        st_d.rvalid = 1'b0;
        // Data lines come from outside the clock domain and pass two flip-flops.
        st_d.din_meta = data_lines_in;
        st_d.din_sync = st_q.din_meta;
        case (st_q.state)
            asr_pkg::ST_IDLE: begin
                st_d.ready = 1'b1;
                // A request with no lane selected is refused; it would strobe nothing.
                if (req_valid_in && st_q.ready && req_byte_en_in != 2'h0) begin
                    // Address goes out a cycle ahead of select.
                    st_d.ready = 1'b0;
                    st_d.pins.word_addr = req_addr_in;
                    st_d.pins.upper_byte_sel_n = ~req_byte_en_in[1];
                    st_d.pins.lower_byte_sel_n = ~req_byte_en_in[0];
                    st_d.wr_pending = req_write_in;
                    st_d.pins.data_out = req_wdata_in;
                    st_d.state = asr_pkg::ST_RSET;
                end
            end
            asr_pkg::ST_RSET: begin
                st_d.pins.chip_sel_n = 1'b0;
                if (st_q.wr_pending) begin
                    // Output enable stays high so the memory never drives.
                    // Unselected lanes are neither driven nor strobed and keep contents.
                    st_d.pins.write_n = 1'b0;
                    st_d.pins.data_oe = {{asr_pkg::BYTE_W{req_en_hi(st_q)}},
                                         {asr_pkg::BYTE_W{req_en_lo(st_q)}}};
                    st_d.cnt = WR_N;
                    st_d.state = asr_pkg::ST_WRIT;
                end else begin
                    // Select and output enable fall together, a cycle after the address.
                    st_d.pins.out_en_n = 1'b0;
                    st_d.cnt = RD_N;
                    st_d.state = asr_pkg::ST_READ;
                end
            end
            asr_pkg::ST_READ: begin
                // Wait covers address access and enable-to-data.
                // Address and byte selects stand until capture, so no stale data mixes in.
                // Reads never strobe write, so the stored word is left as it was.
                if (st_q.cnt == CNT_ONE) begin
                    st_d.rdata = read_mask(st_q, st_q.din_sync);
                    st_d.rvalid = 1'b1;
                    st_d.pins.out_en_n = 1'b1;
                    st_d.pins.chip_sel_n = 1'b1;
                    st_d.cnt = TURN_N;
                    st_d.state = asr_pkg::ST_TURN;
                end else begin
                    st_d.cnt = st_q.cnt - CNT_ONE;
                end
            end
            asr_pkg::ST_WRIT: begin
                // Strobe, select and byte selects all held for the full pulse.
                // One cycle of strobe is ten nanoseconds, above the least pulse.
                if (st_q.cnt == CNT_ONE) begin
                    // Write strobe ends it; data and address held past this edge.
                    st_d.pins.write_n = 1'b1;
                    st_d.cnt = TURN_N;
                    st_d.state = asr_pkg::ST_TURN;
                end else begin
                    st_d.cnt = st_q.cnt - CNT_ONE;
                end
            end
            asr_pkg::ST_TURN: begin
                // Release select a cycle after the strobe, not with it.
                st_d.pins.chip_sel_n = 1'b1;
                st_d.pins.data_oe = 16'h0000;
                st_d.pins.upper_byte_sel_n = 1'b1;
                st_d.pins.lower_byte_sel_n = 1'b1;
                if (st_q.cnt <= CNT_ONE) begin
                    st_d.ready = 1'b1;
                    st_d.state = asr_pkg::ST_IDLE;
                end else begin
                    st_d.cnt = st_q.cnt - CNT_ONE;
                end
            end
            default: begin
                st_d.state = asr_pkg::ST_IDLE;
            end
        endcase
    end

    // Lane helpers read the byte selects already standing on the pins.
    function automatic logic req_en_hi(input asr_pkg::asr_state_s s);
        req_en_hi = ~s.pins.upper_byte_sel_n;
    endfunction : req_en_hi

    function automatic logic req_en_lo(input asr_pkg::asr_state_s s);
        req_en_lo = ~s.pins.lower_byte_sel_n;
    endfunction : req_en_lo

    // Unselected lanes float on the pins, so the mask forces them to zero.
    function automatic logic [15:0] read_mask(input asr_pkg::asr_state_s s,
                                               input logic [15:0] d);
        read_mask = d & {{asr_pkg::BYTE_W{req_en_hi(s)}}, {asr_pkg::BYTE_W{req_en_lo(s)}}};
    endfunction : read_mask

    // Reset parks every strobe high so the memory stays deselected in standby.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q.state <= asr_pkg::ST_IDLE;
            st_q.cnt <= 4'h0;
            st_q.pins.word_addr <= 15'h0000;
            st_q.pins.chip_sel_n <= 1'b1;
            st_q.pins.write_n <= 1'b1;
            st_q.pins.out_en_n <= 1'b1;
            st_q.pins.upper_byte_sel_n <= 1'b1;
            st_q.pins.lower_byte_sel_n <= 1'b1;
            st_q.pins.data_out <= 16'h0000;
            st_q.pins.data_oe <= 16'h0000;
            st_q.ready <= 1'b0;
            st_q.rvalid <= 1'b0;
            st_q.rdata <= 16'h0000;
            st_q.wr_pending <= 1'b0;
            st_q.din_meta <= 16'h0000;
            st_q.din_sync <= 16'h0000;
        end else begin
            st_q <= st_d;
        end
    end

    // Every output is a plain copy of a register field.
    always_comb begin
        req_ready_out = st_q.ready;
        rd_valid_out = st_q.rvalid;
        rd_data_out = st_q.rdata;
        word_addr_out = st_q.pins.word_addr;
        chip_sel_n_out = st_q.pins.chip_sel_n;
        write_n_out = st_q.pins.write_n;
        out_en_n_out = st_q.pins.out_en_n;
        upper_byte_sel_n_out = st_q.pins.upper_byte_sel_n;
        lower_byte_sel_n_out = st_q.pins.lower_byte_sel_n;
        data_lines_out = st_q.pins.data_out;
        data_lines_oe_out = st_q.pins.data_oe;
    end
endmodule : asr_ctrl

// ---- asr_ctrl_chk.sv ----
// Pin timing checker for the static memory host controller.
// Assumes it is bound to asr_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module asr_ctrl_chk #(
    parameter int ADDR_W = 15,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Request side
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [1:0] req_byte_en_in,
    input wire logic req_ready_out,
    input wire logic rd_valid_out,
    // Memory pins
    input wire logic [ADDR_W-1:0] word_addr_out,
    input wire logic chip_sel_n_out,
    input wire logic write_n_out,
    input wire logic out_en_n_out,
    input wire logic upper_byte_sel_n_out,
    input wire logic lower_byte_sel_n_out,
    input wire logic [DATA_W-1:0] data_lines_out,
    input wire logic [DATA_W-1:0] data_lines_oe_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rd_take;
        req_valid_in && req_ready_out && !req_write_in && req_byte_en_in != 2'h0;
    endsequence
    sequence s_wr_take;
        req_valid_in && req_ready_out && req_write_in && req_byte_en_in != 2'h0;
    endsequence
    sequence s_rd_open;
        !chip_sel_n_out && !out_en_n_out && write_n_out;
    endsequence
    sequence s_wr_open;
        !chip_sel_n_out && !write_n_out;
    endsequence
    rd_flow_a: assert property (s_rd_take |=> ##1 s_rd_open [*3] ##1
        (rd_valid_out && chip_sel_n_out)) else $error("read cycle out of step");
    wr_flow_a: assert property (s_wr_take |=> ##1 s_wr_open ##1
        (write_n_out && !chip_sel_n_out) ##1 chip_sel_n_out) else $error("write cycle out of step");
    wr_lanes_a: assert property (!write_n_out |-> data_lines_oe_out ==
        {{8{!upper_byte_sel_n_out}}, {8{!lower_byte_sel_n_out}}}) else $error("write lanes wrong");
    wr_gate_a: assert property (!write_n_out |-> !chip_sel_n_out &&
        !(upper_byte_sel_n_out && lower_byte_sel_n_out)) else $error("write strobe without select");
    no_fight_a: assert property (!out_en_n_out |-> data_lines_oe_out == '0)
        else $error("host drives during read");
    addr_hold_a: assert property (!write_n_out |=> $stable(word_addr_out))
        else $error("address moved at write end");
    data_hold_a: assert property ($rose(write_n_out) |-> $stable(data_lines_out) &&
        !chip_sel_n_out) else $error("data or select moved at write end");
    addr_setup_a: assert property ($fell(write_n_out) || $fell(chip_sel_n_out) |->
        $stable(word_addr_out)) else $error("address late");
    idle_pins_a: assert property (req_ready_out |-> chip_sel_n_out && write_n_out &&
        out_en_n_out) else $error("pins active while idle");
endmodule : asr_ctrl_chk
bind asr_ctrl asr_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) CHK (.*);

// ---- asr_sram_model.sv ----
// Behavioural 32K x 16 static memory with byte lanes.
// Assumes the bench merges its lane drive with the host's onto the data lines.
`timescale 1ns/1ps
module asr_sram_model #(
    parameter int RD_NS = 10
) (
    // Control pins
    input wire logic [14:0] word_addr_in,
    input wire logic chip_sel_n_in,
    input wire logic write_n_in,
    input wire logic out_en_n_in,
    input wire logic upper_byte_sel_n_in,
    input wire logic lower_byte_sel_n_in,
    // Data lines
    input wire logic [15:0] data_lines_in,
    output logic [15:0] data_drv_out,
    output logic [15:0] data_oe_out
);
    logic [15:0] mem [0:32767];
    logic rd;
    assign rd = !chip_sel_n_in && !out_en_n_in && write_n_in;
    assign #(RD_NS) data_drv_out = mem[word_addr_in];
    assign data_oe_out = rd ? {{8{!upper_byte_sel_n_in}}, {8{!lower_byte_sel_n_in}}} : 16'h0000;
    // The last value seen inside the overlap is what stays stored.
    always @* begin
        if (!chip_sel_n_in && !write_n_in) begin
            if (!lower_byte_sel_n_in) mem[word_addr_in][7:0] = data_lines_in[7:0];
            if (!upper_byte_sel_n_in) mem[word_addr_in][15:8] = data_lines_in[15:8];
        end
    end
endmodule : asr_sram_model

// ---- test_async_sram_16bit_byte_lanes.sv ----
// Self-checking bench for the static memory host controller.
// Assumes the checker is bound in and the memory model sits on the pins.
`timescale 1ns/1ps
module test_async_sram_16bit_byte_lanes;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [14:0] req_addr_in = 15'h0000;
    logic [15:0] req_wdata_in = 16'h0000;
    logic [1:0] req_byte_en_in = 2'h0;
    logic req_ready_out, rd_valid_out, chip_sel_n_out, write_n_out, out_en_n_out, flt = 1'b0;
    logic upper_byte_sel_n_out, lower_byte_sel_n_out;
    logic [14:0] word_addr_out;
    logic [15:0] rd_data_out, data_lines_in, data_lines_out, data_lines_oe_out, m_drv, m_oe;
    int num_errors = 0;
    int n_tests = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) flt <= ~flt;
    // Released lines toggle each cycle so a stale value never passes for read data.
    assign data_lines_in = (data_lines_oe_out & data_lines_out) | (m_oe & m_drv)
        | (~data_lines_oe_out & ~m_oe & {16{flt}});
    asr_ctrl DUT (.*);
    asr_sram_model MEM (.word_addr_in(word_addr_out), .chip_sel_n_in(chip_sel_n_out),
        .write_n_in(write_n_out), .out_en_n_in(out_en_n_out),
        .upper_byte_sel_n_in(upper_byte_sel_n_out), .lower_byte_sel_n_in(lower_byte_sel_n_out),
        .data_lines_in(data_lines_in), .data_drv_out(m_drv), .data_oe_out(m_oe));
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask : chk
    task op(input logic w, input logic [14:0] a, input logic [15:0] d, input logic [1:0] be,
        input logic [15:0] e);
        @(negedge sys_clk_in);
        while (req_ready_out !== 1'b1) @(negedge sys_clk_in);
        @(posedge sys_clk_in);
        req_valid_in <= 1'b1;
        req_write_in <= w;
        req_addr_in <= a;
        req_wdata_in <= d;
        req_byte_en_in <= be;
        @(posedge sys_clk_in);
        req_valid_in <= 1'b0;
        if (!w && be != 2'h0) begin
            repeat (4) @(posedge sys_clk_in);
            #1;
            chk("rd_valid_out", 16'h0001, {15'h0000, rd_valid_out});
            chk("rd_data_out", e, rd_data_out);
        end
    endtask : op
    task t_words;
        op(1'b1, 15'h0000, 16'hA55A, 2'h3, 16'h0000);
        op(1'b1, 15'h7FFF, 16'h5AA5, 2'h3, 16'h0000);
        op(1'b0, 15'h0000, 16'h0000, 2'h3, 16'hA55A);
        op(1'b0, 15'h7FFF, 16'h0000, 2'h3, 16'h5AA5);
    endtask : t_words
    task t_lanes;
        op(1'b1, 15'h0005, 16'h1234, 2'h3, 16'h0000);
        op(1'b1, 15'h0005, 16'hABCD, 2'h2, 16'h0000);
        op(1'b0, 15'h0005, 16'h0000, 2'h3, 16'hAB34);
        op(1'b0, 15'h0005, 16'h0000, 2'h1, 16'h0034);
        op(1'b0, 15'h0005, 16'h0000, 2'h2, 16'hAB00);
    endtask : t_lanes
    task t_refuse;
        op(1'b1, 15'h0005, 16'hFFFF, 2'h0, 16'h0000);
        @(negedge sys_clk_in);
        chk("chip_sel_n_out", 16'h0001, {15'h0000, chip_sel_n_out});
        op(1'b0, 15'h0005, 16'h0000, 2'h3, 16'hAB34);
    endtask : t_refuse
    // Reset in the middle of a read must park the pins and leave memory intact.
    task t_reset;
        @(negedge sys_clk_in);
        while (req_ready_out !== 1'b1) @(negedge sys_clk_in);
        @(posedge sys_clk_in);
        req_valid_in <= 1'b1;
        req_write_in <= 1'b0;
        req_addr_in <= 15'h0005;
        req_byte_en_in <= 2'h3;
        @(posedge sys_clk_in);
        req_valid_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        #1;
        chk("chip_sel_n_out", 16'h0001, {15'h0000, chip_sel_n_out});
        chk("out_en_n_out", 16'h0001, {15'h0000, out_en_n_out});
        chk("req_ready_out", 16'h0000, {15'h0000, req_ready_out});
        repeat (4) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        #1;
        chk("req_ready_out", 16'h0001, {15'h0000, req_ready_out});
        op(1'b0, 15'h0005, 16'h0000, 2'h3, 16'hAB34);
    endtask : t_reset
    task give_verdict;
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (16) @(posedge sys_clk_in);
        chk("chip_sel_n_out", 16'h0001, {15'h0000, chip_sel_n_out});
        rst_n_in <= 1'b1;
        t_words();
        t_lanes();
        t_refuse();
        t_reset();
        give_verdict();
    end
    // About a hundred cycles of traffic; this bound is far beyond it.
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
endmodule : test_async_sram_16bit_byte_lanes
